// *** core/fio_port.v ***
// Four-bit bidirectional I/O port with pull-ups, wake-up and an APB register slave.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fio_consts.vh"

// How it works
// - Direction bit one makes the pin an input; data reads return the pin.
// - Direction bit zero drives the pin push-pull with the output latch value.
// - Reading an output pin returns its latch, not the pad level.
// - Input levels are sampled during the read access, never latched ahead.
// - Written data stays in the output latch until software writes it again.
// - Each of the four pull-high bits connects a weak pull-up when set.
// - A pull-up acts only while its pin is configured as input.
// - Each wake bit independently enables wake-up for its own pin.
// - In sleep or idle, a falling edge on a wake-enabled pin wakes the core.
// - Upper bits 31 to four of the control registers read zero.
// - Reset sets all data latch and direction bits to one.
// - Pull and wake bits clear on reset; sleep watchdog time-out keeps them.
// - A pin turned to output after reset drives high unless its latch was written.
// - Bit set and clear are whole-register read-modify-write by software.
// - Each pin maps to one direction bit, changeable at any time.
module fio_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`FIO_ADDR_W-1:0] paddr,
  input wire [`FIO_DATA_W-1:0] pwdata,
  input wire [3:0] pstrb,
  output reg [`FIO_DATA_W-1:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [`FIO_PINS-1:0] pin_in,
  output reg [`FIO_PINS-1:0] pin_out,
  output reg [`FIO_PINS-1:0] pin_oe,
  output reg [`FIO_PINS-1:0] pin_pull_en,
  input wire low_power,
  output reg wake_req,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  reg [`FIO_PINS-1:0] port_data;
  reg [`FIO_PINS-1:0] port_direction;
  reg [`FIO_PINS-1:0] port_pull_high;
  reg [`FIO_PINS-1:0] port_wake_enable;
  reg [`FIO_PINS-1:0] wake_status;
  reg [`FIO_PINS-1:0] wake_mask;
  reg [`FIO_PINS-1:0] status_snap;

  wire [`FIO_PINS-1:0] cell_drive_en;
  wire [`FIO_PINS-1:0] cell_drive_val;
  wire [`FIO_PINS-1:0] cell_pull_en;
  wire [`FIO_PINS-1:0] cell_read;
  wire [`FIO_PINS-1:0] pin_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding, shared by the read and write paths.

  function [2:0] fio_index;
    input [`FIO_ADDR_W-1:0] addr;
    begin
      case (addr)
        `FIO_OFF_PORT_DATA: fio_index = `FIO_IDX_PORT_DATA;
        `FIO_OFF_PORT_DIRECTION: fio_index = `FIO_IDX_PORT_DIRECTION;
        `FIO_OFF_PORT_PULL_HIGH: fio_index = `FIO_IDX_PORT_PULL_HIGH;
        `FIO_OFF_PORT_WAKE_ENABLE: fio_index = `FIO_IDX_PORT_WAKE_ENABLE;
        `FIO_OFF_WAKE_STATUS: fio_index = `FIO_IDX_WAKE_STATUS;
        `FIO_OFF_WAKE_MASK: fio_index = `FIO_IDX_WAKE_MASK;
        default: fio_index = `FIO_IDX_NONE;
      endcase
    end
  endfunction

  // Places a four-bit field in the low bits of a bus word, upper bits zero.
  function [`FIO_DATA_W-1:0] fio_word;
    input [`FIO_PINS-1:0] field;
    begin
      fio_word = {{(`FIO_DATA_W-`FIO_PINS){1'b0}}, field};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: every access phase takes two cycles so that all answers
  // come from flops; the first access cycle samples, the second completes.

  wire acc_first;
  wire acc_done;
  wire [2:0] req_index;
  wire req_mapped;
  wire wr_done;
  wire rd_done;
  wire lane0;

  assign acc_first = psel & penable & ~pready;
  assign acc_done = psel & penable & pready;
  assign req_index = fio_index(paddr);
  assign req_mapped = (req_index != `FIO_IDX_NONE);
  assign lane0 = pstrb[0];
  assign wr_done = acc_done & pwrite & req_mapped & ~pslverr;
  assign rd_done = acc_done & ~pwrite & req_mapped;

  reg [`FIO_DATA_W-1:0] next_prdata;

  // Input pins are read live in the sampling cycle of the access.
  always @* begin
    next_prdata = {`FIO_DATA_W{1'b0}};
    case (req_index)
      `FIO_IDX_PORT_DATA: next_prdata = fio_word(cell_read);
      `FIO_IDX_PORT_DIRECTION: next_prdata = fio_word(port_direction);
      `FIO_IDX_PORT_PULL_HIGH: next_prdata = fio_word(port_pull_high);
      `FIO_IDX_PORT_WAKE_ENABLE: next_prdata = fio_word(port_wake_enable);
      `FIO_IDX_WAKE_STATUS: next_prdata = fio_word(wake_status);
      `FIO_IDX_WAKE_MASK: next_prdata = fio_word(wake_mask);
      default: next_prdata = {`FIO_DATA_W{1'b0}};
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {`FIO_DATA_W{1'b0}};
    end else begin
      pready <= acc_first;
      if (acc_first) begin
        // Writes to the read-only status register are refused like holes.
        pslverr <= ~req_mapped | (pwrite & (req_index == `FIO_IDX_WAKE_STATUS));
        prdata <= pwrite ? {`FIO_DATA_W{1'b0}} : next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers. A sleep-mode watchdog time-out must not reach
  // presetn, which is how these registers keep their contents across it.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data <= `FIO_RST_PORT_DATA;
      port_direction <= `FIO_RST_PORT_DIRECTION;
      port_pull_high <= `FIO_RST_PORT_PULL_HIGH;
      port_wake_enable <= `FIO_RST_PORT_WAKE_ENABLE;
      wake_mask <= `FIO_RST_WAKE_MASK;
    end else if (wr_done & lane0) begin
      // Whole-register writes only; bit operations are done by software.
      case (req_index)
        `FIO_IDX_PORT_DATA: port_data <= pwdata[`FIO_PIN_MSB:`FIO_PIN_LSB];
        `FIO_IDX_PORT_DIRECTION: port_direction <= pwdata[`FIO_PIN_MSB:`FIO_PIN_LSB];
        `FIO_IDX_PORT_PULL_HIGH: port_pull_high <= pwdata[`FIO_PIN_MSB:`FIO_PIN_LSB];
        `FIO_IDX_PORT_WAKE_ENABLE: port_wake_enable <= pwdata[`FIO_PIN_MSB:`FIO_PIN_LSB];
        `FIO_IDX_WAKE_MASK: wake_mask <= pwdata[`FIO_PIN_MSB:`FIO_PIN_LSB];
        default: port_data <= port_data;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin logic.

  genvar gi;
  generate
    for (gi = 0; gi < `FIO_PINS; gi = gi + 1) begin : g_pin
      fio_pin_cell u_cell (
        .direction_bit(port_direction[gi]),
        .latch_bit(port_data[gi]),
        .pull_bit(port_pull_high[gi]),
        .pin_level(pin_in[gi]),
        .drive_en(cell_drive_en[gi]),
        .drive_val(cell_drive_val[gi]),
        .pull_en(cell_pull_en[gi]),
        .read_bit(cell_read[gi])
      );
      fio_wake_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_level(pin_in[gi]),
        .wake_bit(port_wake_enable[gi]),
        .fall(pin_fall[gi])
      );
    end
  endgenerate

  // Pad controls are registered, so they follow a register write by one cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= {`FIO_PINS{1'b0}};
      pin_out <= `FIO_RST_PORT_DATA;
      pin_pull_en <= {`FIO_PINS{1'b0}};
    end else begin
      pin_oe <= cell_drive_en;
      pin_out <= cell_drive_val;
      pin_pull_en <= cell_pull_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake status, interrupt and wake request.

  wire status_rd_done;
  wire [`FIO_PINS-1:0] status_clear;
  wire [`FIO_PINS-1:0] next_wake_status;

  assign status_rd_done = rd_done & (req_index == `FIO_IDX_WAKE_STATUS);
  // Only bits that were reported are cleared, and a new edge wins over the clear.
  assign status_clear = status_rd_done ? status_snap : {`FIO_PINS{1'b0}};
  assign next_wake_status = (wake_status & ~status_clear) | pin_fall;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_status <= `FIO_RST_WAKE_STATUS;
      status_snap <= {`FIO_PINS{1'b0}};
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      wake_status <= next_wake_status;
      if (acc_first) begin
        status_snap <= wake_status;
      end
      irq <= |(next_wake_status & wake_mask);
      // Held until the core leaves the low-power state.
      wake_req <= low_power & (wake_req | (|pin_fall));
    end
  end

endmodule

`default_nettype wire

// *** shared/fio_consts.vh ***
// Constants for the four-bit I/O port with wake-up: offsets, fields, reset values.
`ifndef FIO_CONSTS_VH
`define FIO_CONSTS_VH

// Port and register widths.
`define FIO_PINS 4
`define FIO_DATA_W 32
`define FIO_ADDR_W 32

// Byte addresses of the registers on the APB bus.
`define FIO_OFF_PORT_DATA 32'h0000_0000
`define FIO_OFF_PORT_DIRECTION 32'h0000_0004
`define FIO_OFF_PORT_PULL_HIGH 32'h0000_0008
`define FIO_OFF_PORT_WAKE_ENABLE 32'h0000_000c
`define FIO_OFF_WAKE_STATUS 32'h0000_0010
`define FIO_OFF_WAKE_MASK 32'h0000_0014

// Decoded register indices.
`define FIO_IDX_PORT_DATA 3'h0
`define FIO_IDX_PORT_DIRECTION 3'h1
`define FIO_IDX_PORT_PULL_HIGH 3'h2
`define FIO_IDX_PORT_WAKE_ENABLE 3'h3
`define FIO_IDX_WAKE_STATUS 3'h4
`define FIO_IDX_WAKE_MASK 3'h5
`define FIO_IDX_NONE 3'h7

// Field position of the four implemented pin bits.
`define FIO_PIN_LSB 0
`define FIO_PIN_MSB 3

// Reset values.
`define FIO_RST_PORT_DATA 4'hf
`define FIO_RST_PORT_DIRECTION 4'hf
`define FIO_RST_PORT_PULL_HIGH 4'h0
`define FIO_RST_PORT_WAKE_ENABLE 4'h0
`define FIO_RST_WAKE_STATUS 4'h0
`define FIO_RST_WAKE_MASK 4'h0
`define FIO_RST_PIN_SYNC 1'b1

`endif

// *** core/fio_wake_sync.v ***
// Synchroniser and gated falling-edge detector for one port pin.
`timescale 1ns/1ps
`default_nettype none
`include "fio_consts.vh"

module fio_wake_sync (
  input wire pclk,
  input wire presetn,
  input wire pin_level,
  input wire wake_bit,
  output wire fall
);

  reg sync_meta;
  reg sync_level;
  reg sync_prev;

  // Flops start high so an idle pulled-up pin does not look like an edge after reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= `FIO_RST_PIN_SYNC;
      sync_level <= `FIO_RST_PIN_SYNC;
      sync_prev <= `FIO_RST_PIN_SYNC;
    end else begin
      sync_meta <= pin_level;
      sync_level <= sync_meta;
      sync_prev <= sync_level;
    end
  end

  // Only a pin whose wake bit is set may report a high-to-low change.
  assign fall = wake_bit & sync_prev & ~sync_level;

endmodule

`default_nettype wire

// *** core/fio_pin_cell.v ***
// Per-pin pad steering and read-back selection for the I/O port.
`timescale 1ns/1ps
`default_nettype none

module fio_pin_cell (
  input wire direction_bit,
  input wire latch_bit,
  input wire pull_bit,
  input wire pin_level,
  output wire drive_en,
  output wire drive_val,
  output wire pull_en,
  output wire read_bit
);

  // A zero direction bit makes the pin a push-pull output of the latch.
  assign drive_en = ~direction_bit;
  assign drive_val = latch_bit;

  // The weak pull-up is only allowed while the pin is an input.
  assign pull_en = pull_bit & direction_bit;

  // Inputs read the live pin; outputs read the latch, not the pad.
  assign read_bit = direction_bit ? pin_level : latch_bit;

endmodule

`default_nettype wire

// *** tb/fio_port_asserts.sv ***
// Concurrent checks on the I/O port's bus, pad and wake outputs.
`timescale 1ns/1ps
`default_nettype none
`include "fio_consts.vh"
module fio_port_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pull_en,
  input wire logic low_power,
  input wire logic wake_req,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic wr_data;
  logic [3:0] wd;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  assign wr_data = wr && paddr == `FIO_OFF_PORT_DATA;
  assign wd = pwdata[3:0];
  ////////////////////////////////////////
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_bad_addr_err: assert property (psel && penable && pready
    && (paddr > 32'h14 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:4] == 28'h0)
    else $error("upper read bits not zero");
  a_oe_from_dir: assert property (wr && paddr == `FIO_OFF_PORT_DIRECTION
    |-> ##2 pin_oe == ~$past(wd, 2))
    else $error("pin_oe does not follow direction");
  a_out_from_latch: assert property (wr_data |-> ##2 pin_out == $past(wd, 2))
    else $error("pin_out does not follow latch");
  a_out_hold: assert property (!$past(wr_data, 2) |-> $stable(pin_out))
    else $error("pin_out changed without a write");
  a_pull_set: assert property (wr && paddr == `FIO_OFF_PORT_PULL_HIGH
    |-> ##2 pin_pull_en == ($past(wd, 2) & ~pin_oe))
    else $error("pin_pull_en wrong after write");
  a_pull_inputs: assert property ((pin_oe & pin_pull_en) == 4'h0)
    else $error("pull-up on an output pin");
  a_wake_awake: assert property (!low_power |=> !wake_req)
    else $error("wake_req while awake");
  c_error: cover property (pready && pslverr);
  c_wake: cover property ($rose(wake_req));
  c_irq: cover property ($rose(irq));
endmodule
bind fio_port fio_port_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .low_power(low_power),
  .wake_req(wake_req), .irq(irq));
`default_nettype wire

// *** tb/fio_pins_model.sv ***
// Pad-side model: external switches, weak pull-ups and floating pads.
`timescale 1ns/1ps
`default_nettype none
module fio_pins_model (
  input wire logic pclk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pull_en,
  input wire logic [3:0] sw_en,
  input wire logic [3:0] sw_lvl,
  output logic [3:0] pin_in
);
  logic [3:0] flt = 4'h0;
  // A floating pad toggles each cycle so that no kept level can pass for valid data.
  always @(posedge pclk) begin
    flt <= ~flt;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (sw_en[i]) pin_in[i] = sw_lvl[i];
      else if (pin_pull_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = flt[i];
    end
  end
endmodule
`default_nettype wire

// *** tb/four_bit_io_port_with_wake_tb.sv ***
// Self-checking bench of the four-bit I/O port with wake-up.
`timescale 1ns/1ps
`default_nettype none
`include "fio_consts.vh"
module four_bit_io_port_with_wake_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, r, seed = 32'hb2b1;
  logic [3:0] pstrb = 4'hf, pin_in, pin_out, pin_oe, pin_pull_en, d, c, s, e;
  logic [3:0] sw_en = 4'hf, sw = 4'ha;
  logic pready, pslverr, low_power = 1'b0, wake_req, irq, er;
  int err_total = 0, comparisons = 0;
  initial forever #5 pclk = ~pclk;
  fio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .low_power(low_power),
    .wake_req(wake_req), .irq(irq));
  fio_pins_model pad_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_en(pin_pull_en), .sw_en(sw_en), .sw_lvl(sw), .pin_in(pin_in));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Inputs without a switch rely on the pull-up, so they read high.
  function automatic logic [31:0] port_exp(logic [3:0] c, d, s, e);
    return {28'h0, (~c & d) | (c & (s | ~e))};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic reset_chk();
    logic [31:0] ex [5] = '{32'hf, 32'h0, 32'h0, 32'h0, 32'h0};
    chk("oe", 32'h0, {28'h0, pin_oe});
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 32'h4 * (i + 1), 32'h0);
      chk("reset reg", ex[i], rd);
    end
    // Turning pins to outputs right after reset must drive the reset latch value.
    apb(1'b1, `FIO_OFF_PORT_DIRECTION, 32'h0);
    @(posedge pclk);
    chk("oe", 32'hf, {28'h0, pin_oe});
    chk("out", 32'hf, {28'h0, pin_out});
    apb(1'b0, `FIO_OFF_PORT_DATA, 32'h0);
    chk("data", 32'hf, rd);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_chk();
    repeat (16) begin
      r = rnd();
      {s, e, c, d} = {r[15:12], r[19:16] | ~r[11:8], r[7:4], r[3:0]};
      sw <= s;
      sw_en <= e;
      apb(1'b1, `FIO_OFF_PORT_DATA, r);
      apb(1'b1, `FIO_OFF_PORT_DIRECTION, r >> 4);
      apb(1'b1, `FIO_OFF_PORT_PULL_HIGH, r >> 8);
      apb(1'b0, `FIO_OFF_PORT_DIRECTION, 32'h0);
      chk("dir", {28'h0, c}, rd);
      chk("oe", {28'h0, ~c}, {28'h0, pin_oe});
      chk("out", {28'h0, d}, {28'h0, pin_out});
      chk("pull", {28'h0, r[11:8] & c}, {28'h0, pin_pull_en});
      apb(1'b0, `FIO_OFF_PORT_DATA, 32'h0);
      chk("data", port_exp(c, d, s, e), rd);
    end
    apb(1'b0, `FIO_OFF_PORT_DIRECTION, 32'h0);
    apb(1'b1, `FIO_OFF_PORT_DIRECTION, rd ^ 32'h1);
    apb(1'b0, `FIO_OFF_PORT_DIRECTION, 32'h0);
    chk("rmw", {28'h0, c ^ 4'h1}, rd);
    pstrb <= 4'he;
    apb(1'b1, `FIO_OFF_PORT_DIRECTION, 32'h0);
    chk("err", 32'h0, {31'h0, er});
    pstrb <= 4'hf;
    apb(1'b0, `FIO_OFF_PORT_DIRECTION, 32'h0);
    chk("strobe", {28'h0, c ^ 4'h1}, rd);
    apb(1'b0, 32'h18, 32'h0);
    chk("err", 32'h1, {31'h0, er});
    chk("err data", 32'h0, rd);
    apb(1'b1, `FIO_OFF_WAKE_STATUS, 32'hf);
    chk("err", 32'h1, {31'h0, er});
    sw_en <= 4'hf;
    sw <= 4'hf;
    apb(1'b1, `FIO_OFF_PORT_DIRECTION, 32'hf);
    apb(1'b1, `FIO_OFF_PORT_WAKE_ENABLE, 32'h5);
    apb(1'b1, `FIO_OFF_WAKE_MASK, 32'hf);
    low_power <= 1'b1;
    sw <= 4'hd;
    repeat (8) @(posedge pclk);
    chk("wake", 32'h0, {31'h0, wake_req});
    sw <= 4'h9;
    repeat (6) @(posedge pclk);
    chk("wake", 32'h1, {31'h0, wake_req});
    chk("irq", 32'h1, {31'h0, irq});
    low_power <= 1'b0;
    apb(1'b1, `FIO_OFF_WAKE_MASK, 32'h0);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("wake", 32'h0, {31'h0, wake_req});
    apb(1'b0, `FIO_OFF_WAKE_STATUS, 32'h0);
    chk("status", 32'h4, rd);
    sw <= 4'h8;
    repeat (6) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, `FIO_OFF_WAKE_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b0, `FIO_OFF_WAKE_STATUS, 32'h0);
    chk("status clear", 32'h0, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_chk();
    print_verdict();
  end
endmodule
`default_nettype wire
